// File: sofs_pkg.sv
// Package of constants and LED encodings for the output fault supervisor
package sofs_pkg;
	localparam int unsigned POINTS = 16;
	localparam int unsigned GROUP_SIZE = 8;
	localparam int unsigned CLK_HZ = 50000000;
	// Sustained overcurrent trip time in ms
	localparam int unsigned OVERLOAD_MS = 10;
	localparam int unsigned OVERLOAD_CYCLES = (CLK_HZ / 1000) * OVERLOAD_MS;
	// Blink half period in ms
	localparam int unsigned BLINK_MS = 250;
	localparam int unsigned BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;
	// Two-bit indicator colour codes
	localparam logic [1:0] LED_OFF = 2'h0;
	localparam logic [1:0] LED_GREEN = 2'h1;
	localparam logic [1:0] LED_AMBER = 2'h2;
	localparam logic [1:0] LED_RED = 2'h3;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [3:0] ERR_CODE_RESET = 4'h0;
endpackage : sofs_pkg

// File: sofs_sync.sv
// Two flip-flop synchroniser for a bus of level inputs
`timescale 1ns/100ps
module sofs_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;
	sync_state_t st_reg;
	sync_state_t st_next;
	always_comb
	begin
		st_next.first = d_i;
		st_next.second = st_reg.first;
	end
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign q_o = st_reg.second;
endmodule : sofs_sync

// File: sofs_point.sv
// One output point: overcurrent trip and fault latch
`timescale 1ns/100ps
module sofs_point #(
	parameter int unsigned TRIP_CYCLES = sofs_pkg::OVERLOAD_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic cmd_i,
	input wire logic surge_i,
	input wire logic over_i,
	input wire logic hot_i,
	output logic drive_o,
	output logic fault_o
);
	typedef struct packed {
		logic [23:0] cnt;
		logic fault;
	} point_state_t;
	point_state_t st_reg;
	point_state_t st_next;
	logic trip;
	always_comb
	begin
		st_next = st_reg;
		trip = 1'b0;
		if (over_i && st_reg.cnt < 24'(TRIP_CYCLES))
			st_next.cnt = st_reg.cnt + 24'h000001;
		else if (!over_i)
			st_next.cnt = 24'h000000;
		// Surge, sustained overcurrent or overheating trips the point
		if (surge_i || hot_i || (over_i && st_reg.cnt >= 24'(TRIP_CYCLES)))
			trip = 1'b1;
		// Fault clears only once cause is gone and command is off
		if (trip)
			st_next.fault = 1'b1;
		else if (!cmd_i && !surge_i && !over_i && !hot_i)
			st_next.fault = 1'b0;
	end
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign fault_o = st_reg.fault;
	assign drive_o = cmd_i && !st_reg.fault && !trip;
	property p_fault_hold;
		@(posedge clk_i) disable iff (!reset_n_i)
		(st_reg.fault && cmd_i) |=> st_reg.fault;
	endproperty
	a_fault_hold: assert property (p_fault_hold)
		else $error("Point fault cleared while commanded on");
	property p_surge_trip;
		@(posedge clk_i) disable iff (!reset_n_i)
		surge_i |-> (!drive_o ##1 fault_o);
	endproperty
	a_surge_trip: assert property (p_surge_trip)
		else $error("Surge did not trip the point");
	property p_off_cmd;
		@(posedge clk_i) disable iff (!reset_n_i)
		!cmd_i |-> !drive_o;
	endproperty
	a_off_cmd: assert property (p_off_cmd)
		else $error("Point driven while commanded off");
endmodule : sofs_point

// File: sofs_top.sv
// Smart output fault supervisor: points, status, indicators
// Notes on behaviour
// - Sixteen points, two groups of eight
// - Trip on surge or sustained overcurrent
// - Fault latched until cause gone, commanded off
// - Log terminal block attach and loss events
// - Report field power loss, group fault, block
// - Module indicator dark or solid green
// - Blink green while unconfigured or config failed
// - Amber on watchdog, blink pattern on error
// - Channel indicator off, green, amber fault
// - Group indicator off, green, red
// - Field power error on voltage mismatch
// - Update mode blinks module and group indicators green together
// - Flag no-load below threshold when enabled
// - Command one is on, zero is off
`timescale 1ns/100ps
module sofs_top #(
	parameter int unsigned TRIP_CYCLES = sofs_pkg::OVERLOAD_CYCLES,
	parameter int unsigned BLINK_CYCLES = sofs_pkg::BLINK_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [15:0] cmd_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_lost_i,
	input wire logic [15:0] fallback_hold_i,
	input wire logic [15:0] fallback_value_i,
	input wire logic [15:0] noload_enable_i,
	input wire logic cfg_high_voltage_i,
	input wire logic configured_i,
	input wire logic selftest_fail_i,
	input wire logic watchdog_timeout_i,
	input wire logic internal_error_i,
	input wire logic [3:0] error_code_i,
	input wire logic update_mode_i,
	input wire logic [15:0] surge_i,
	input wire logic [15:0] overcurrent_i,
	input wire logic [15:0] overtemp_i,
	input wire logic [15:0] low_current_i,
	input wire logic [1:0] field_low_present_i,
	input wire logic [1:0] field_high_present_i,
	input wire logic block_present_i,
	output logic [15:0] point_drive_o,
	output logic [15:0] point_fault_o,
	output logic [15:0] noload_o,
	output logic [1:0] field_power_lost_o,
	output logic [1:0] field_power_error_o,
	output logic [1:0] group_fault_o,
	output logic block_on_o,
	output logic block_added_o,
	output logic block_lost_o,
	output logic [1:0] module_indicator_o,
	output logic [31:0] channel_indicator_o,
	output logic [1:0] group1_field_indicator_o,
	output logic [1:0] group2_field_indicator_o
);
	localparam int unsigned NP = sofs_pkg::POINTS;
	localparam int unsigned GS = sofs_pkg::GROUP_SIZE;
	typedef struct packed {
		logic [15:0] cmd;
		logic [15:0] drive;
		logic [15:0] fault;
		logic [15:0] noload;
		logic [1:0] lost;
		logic [1:0] perr;
		logic [1:0] gfault;
		logic block;
		logic block_seen;
		logic added;
		logic removed;
		logic [25:0] blink_cnt;
		logic blink;
		logic [3:0] pulse_cnt;
		logic [1:0] mod_led;
		logic [31:0] ch_led;
		logic [1:0] g1_led;
		logic [1:0] g2_led;
	} top_state_t;
	top_state_t st_reg;
	top_state_t st_next;
	logic [15:0] surge_s;
	logic [15:0] over_s;
	logic [15:0] hot_s;
	logic [15:0] low_s;
	logic [4:0] misc_s;
	logic [15:0] pt_drive;
	logic [15:0] pt_fault;
	logic [15:0] eff_cmd;
	logic [1:0] g_led [2];
	// Field-side sense lines arrive from the isolated domain
	sofs_sync #(.WIDTH(16)) u_sync_surge (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .d_i(surge_i), .q_o(surge_s));
	sofs_sync #(.WIDTH(16)) u_sync_over (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .d_i(overcurrent_i), .q_o(over_s));
	sofs_sync #(.WIDTH(16)) u_sync_hot (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .d_i(overtemp_i), .q_o(hot_s));
	sofs_sync #(.WIDTH(16)) u_sync_low (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .d_i(low_current_i), .q_o(low_s));
	sofs_sync #(.WIDTH(5)) u_sync_misc (.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.d_i({block_present_i, field_high_present_i, field_low_present_i}),
		.q_o(misc_s));
	// Command word lands bit 0 on point 1; fallback on lost link
	always_comb
	begin
		for (int i = 0; i < NP; i++)
		begin
			if (cmd_lost_i && !fallback_hold_i[i])
				eff_cmd[i] = fallback_value_i[i];
			else
				eff_cmd[i] = st_reg.cmd[i];
		end
	end
	genvar g;
	generate
		for (g = 0; g < NP; g++)
		begin : gen_point
			sofs_point #(.TRIP_CYCLES(TRIP_CYCLES)) u_point (
				.clk_i(clk_i),
				.reset_n_i(reset_n_i),
				.cmd_i(eff_cmd[g]),
				.surge_i(surge_s[g]),
				.over_i(over_s[g]),
				.hot_i(hot_s[g]),
				.drive_o(pt_drive[g]),
				.fault_o(pt_fault[g])
			);
		end
	endgenerate
	function automatic logic [1:0] group_led(input logic blk,
		input logic present, input logic err, input logic upd,
		input logic blink);
		if (upd)
			group_led = blink ? sofs_pkg::LED_GREEN : sofs_pkg::LED_OFF;
		else if (!blk || err)
			group_led = sofs_pkg::LED_RED;
		else if (present)
			group_led = sofs_pkg::LED_GREEN;
		else
			group_led = sofs_pkg::LED_OFF;
	endfunction : group_led
	always_comb
	begin
		st_next = st_reg;
		g_led[0] = sofs_pkg::LED_OFF;
		g_led[1] = sofs_pkg::LED_OFF;
		// Hold last valid command; link hold otherwise
		if (cmd_valid_i)
			st_next.cmd = cmd_i;
		st_next.drive = pt_drive;
		st_next.fault = pt_fault;
		st_next.noload = noload_enable_i & pt_drive & low_s;
		// Blink timebase
		if (st_reg.blink_cnt >= 26'(BLINK_CYCLES - 1))
		begin
			st_next.blink_cnt = 26'h0000000;
			st_next.blink = !st_reg.blink;
			if (st_reg.blink)
				st_next.pulse_cnt = st_reg.pulse_cnt + 4'h1;
		end
		else
			st_next.blink_cnt = st_reg.blink_cnt + 26'h0000001;
		for (int k = 0; k < 2; k++)
		begin
			st_next.lost[k] = !misc_s[k] && !misc_s[k + 2];
			// Mismatch between detected and configured supply
			st_next.perr[k] = cfg_high_voltage_i ?
				(misc_s[k] && !misc_s[k + 2]) :
				misc_s[k + 2];
			st_next.gfault[k] = |pt_fault[k*GS +: GS];
			g_led[k] = group_led(misc_s[4], !st_next.lost[k],
				st_next.perr[k], update_mode_i, st_reg.blink);
		end
		st_next.g1_led = g_led[0];
		st_next.g2_led = g_led[1];
		// Terminal block edge events, one pulse each
		st_next.block = misc_s[4];
		st_next.block_seen = st_reg.block;
		st_next.added = st_reg.block && !st_reg.block_seen;
		st_next.removed = !st_reg.block && st_reg.block_seen;
		for (int i = 0; i < NP; i++)
		begin
			if (pt_fault[i])
				st_next.ch_led[2*i +: 2] = sofs_pkg::LED_AMBER;
			else if (pt_drive[i])
				st_next.ch_led[2*i +: 2] = sofs_pkg::LED_GREEN;
			else
				st_next.ch_led[2*i +: 2] = sofs_pkg::LED_OFF;
		end
		// Module indicator priority
		if (update_mode_i)
			st_next.mod_led = st_reg.blink ? sofs_pkg::LED_GREEN :
				sofs_pkg::LED_OFF;
		else if (selftest_fail_i)
			st_next.mod_led = sofs_pkg::LED_OFF;
		else if (watchdog_timeout_i)
			st_next.mod_led = sofs_pkg::LED_AMBER;
		else if (internal_error_i)
			// Pulse count selects number of bursts encoding error code
			st_next.mod_led = (st_reg.blink &&
				st_reg.pulse_cnt <= error_code_i) ?
				sofs_pkg::LED_AMBER : sofs_pkg::LED_OFF;
		else if (!configured_i)
			st_next.mod_led = st_reg.blink ? sofs_pkg::LED_GREEN :
				sofs_pkg::LED_OFF;
		else
			st_next.mod_led = sofs_pkg::LED_GREEN;
	end
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st_reg <= '0;
			st_reg.g1_led <= sofs_pkg::LED_RED;
			st_reg.g2_led <= sofs_pkg::LED_RED;
		end
		else
			st_reg <= st_next;
	end
	assign point_drive_o = st_reg.drive;
	assign point_fault_o = st_reg.fault;
	assign noload_o = st_reg.noload;
	assign field_power_lost_o = st_reg.lost;
	assign field_power_error_o = st_reg.perr;
	assign group_fault_o = st_reg.gfault;
	assign block_on_o = st_reg.block;
	assign block_added_o = st_reg.added;
	assign block_lost_o = st_reg.removed;
	assign module_indicator_o = st_reg.mod_led;
	assign channel_indicator_o = st_reg.ch_led;
	assign group1_field_indicator_o = st_reg.g1_led;
	assign group2_field_indicator_o = st_reg.g2_led;
	property p_block_added;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(block_on_o) |=> block_added_o ##1 !block_added_o;
	endproperty
	a_block_added: assert property (p_block_added)
		else $error("Block attach not reported once");
	property p_block_lost;
		@(posedge clk_i) disable iff (!reset_n_i)
		$fell(block_on_o) |=> block_lost_o;
	endproperty
	a_block_lost: assert property (p_block_lost)
		else $error("Block loss not reported");
	property p_ch_amber;
		@(posedge clk_i) disable iff (!reset_n_i)
		pt_fault[0] |=> channel_indicator_o[1:0] == sofs_pkg::LED_AMBER;
	endproperty
	a_ch_amber: assert property (p_ch_amber)
		else $error("Faulted channel not amber");
	property p_group_red;
		@(posedge clk_i) disable iff (!reset_n_i)
		(!update_mode_i && !misc_s[4]) |=>
			group1_field_indicator_o == sofs_pkg::LED_RED;
	endproperty
	a_group_red: assert property (p_group_red)
		else $error("Group indicator not red without block");
	property p_module_green;
		@(posedge clk_i) disable iff (!reset_n_i)
		(configured_i && !update_mode_i && !selftest_fail_i &&
			!watchdog_timeout_i && !internal_error_i) |=>
			module_indicator_o == sofs_pkg::LED_GREEN;
	endproperty
	a_module_green: assert property (p_module_green)
		else $error("Healthy module not solid green");
	property p_watchdog;
		@(posedge clk_i) disable iff (!reset_n_i)
		(watchdog_timeout_i && !update_mode_i && !selftest_fail_i) |=>
			module_indicator_o == sofs_pkg::LED_AMBER;
	endproperty
	a_watchdog: assert property (p_watchdog)
		else $error("Watchdog timeout not amber");
	property p_unison;
		@(posedge clk_i) disable iff (!reset_n_i)
		(update_mode_i && $past(update_mode_i)) |->
			(module_indicator_o == group1_field_indicator_o &&
			group2_field_indicator_o == group1_field_indicator_o);
	endproperty
	a_unison: assert property (p_unison)
		else $error("Update mode indicators not in step");
	property p_noload;
		@(posedge clk_i) disable iff (!reset_n_i)
		(!noload_enable_i[0] || !pt_drive[0]) |=> !noload_o[0];
	endproperty
	a_noload: assert property (p_noload)
		else $error("No-load flagged while disabled or off");
	property p_perr;
		@(posedge clk_i) disable iff (!reset_n_i)
		(!cfg_high_voltage_i && misc_s[2]) |=> field_power_error_o[0];
	endproperty
	a_perr: assert property (p_perr)
		else $error("High supply on low config not flagged");
endmodule : sofs_top

// File: ctrl_model.sv
// Controller model that sends output command words to the supervisor
`timescale 1ns/100ps
module ctrl_model (
	input wire logic clk_i,
	output logic [15:0] cmd_o,
	output logic cmd_valid_o
);
	initial
	begin
		cmd_o = 16'hffff;
		cmd_valid_o = 1'b0;
	end

	// Word held across one rising edge, then released; gap gives a slow reply
	task send(input logic [15:0] word, input int unsigned gap);
		repeat (gap) @(negedge clk_i);
		@(negedge clk_i);
		cmd_o = word;
		cmd_valid_o = 1'b1;
		@(negedge clk_i);
		cmd_valid_o = 1'b0;
		// A released word is not held, so show its inverse
		cmd_o = ~word;
	endtask : send
endmodule : ctrl_model

// File: smart_output_fault_supervisor_tb.sv
// Self-checking testbench for the output fault supervisor
`timescale 1ns/100ps
module smart_output_fault_supervisor_tb;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [15:0] cmd, hold, fb_val, nl_en, surge, over, hot, lowc;
	logic cmd_valid, lost, cfg_hi, cfgd, st_fail, wdog, ierr, upd, blk;
	logic [3:0] ecode;
	logic [3:0] seen;
	logic [1:0] f_lo, f_hi, pw_lost, pw_err, g_fault, mod_led, g1_led, g2_led;
	logic [15:0] drive, fault, noload;
	logic blk_on, blk_add, blk_lost;
	logic [31:0] ch_led;
	int fails = 0;
	int n_checks = 0;
	int pulses;
	int skew;
	int bursts;
	logic [1:0] prev_led;

	always #10 clk_i = ~clk_i;

	ctrl_model u_ctrl_model (.clk_i(clk_i), .cmd_o(cmd), .cmd_valid_o(cmd_valid));

	sofs_top #(.TRIP_CYCLES(20), .BLINK_CYCLES(4)) u_sofs_top (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd),
		.cmd_valid_i(cmd_valid), .cmd_lost_i(lost), .fallback_hold_i(hold),
		.fallback_value_i(fb_val), .noload_enable_i(nl_en),
		.cfg_high_voltage_i(cfg_hi), .configured_i(cfgd),
		.selftest_fail_i(st_fail), .watchdog_timeout_i(wdog),
		.internal_error_i(ierr), .error_code_i(ecode), .update_mode_i(upd),
		.surge_i(surge), .overcurrent_i(over), .overtemp_i(hot),
		.low_current_i(lowc), .field_low_present_i(f_lo),
		.field_high_present_i(f_hi), .block_present_i(blk),
		.point_drive_o(drive), .point_fault_o(fault), .noload_o(noload),
		.field_power_lost_o(pw_lost), .field_power_error_o(pw_err),
		.group_fault_o(g_fault), .block_on_o(blk_on),
		.block_added_o(blk_add), .block_lost_o(blk_lost),
		.module_indicator_o(mod_led), .channel_indicator_o(ch_led),
		.group1_field_indicator_o(g1_led), .group2_field_indicator_o(g2_led)
	);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task step(input int n);
		repeat (n) @(negedge clk_i);
	endtask : step

	// Collects module colours, amber bursts, block events and indicator skew
	task watch(input int n);
		step(3);
		seen = 4'h0;
		pulses = 0;
		skew = 0;
		bursts = 0;
		prev_led = mod_led;
		repeat (n)
		begin
			@(negedge clk_i);
			seen[mod_led] = 1'b1;
			pulses += int'(blk_lost) + 16 * int'(blk_add);
			if (g1_led !== mod_led || g2_led !== mod_led)
				skew++;
			if (mod_led == 2'h2 && prev_led != 2'h2)
				bursts++;
			prev_led = mod_led;
		end
	endtask : watch

	task field(input logic c, input logic [1:0] lo, hi, err, pl, l1, l2);
		cfg_hi = c;
		f_lo = lo;
		f_hi = hi;
		step(6);
		chk(32'(pw_err), 32'(err));
		chk(32'(pw_lost), 32'(pl));
		chk(32'(g1_led), 32'(l1));
		chk(32'(g2_led), 32'(l2));
	endtask : field

	task final_report;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (20000) @(negedge clk_i);
		fails++;
		final_report();
	end

	initial
	begin
		{hold, fb_val, nl_en} = {16'hffff, 16'h0000, 16'h0000};
		{surge, over, hot, lowc} = 64'h0;
		{lost, cfg_hi, cfgd, st_fail, wdog, ierr, upd, blk} = 8'h21;
		ecode = 4'h2;
		f_lo = 2'h3;
		f_hi = 2'h0;
		step(6);
		chk(32'(drive), 32'h0);
		chk(ch_led, 32'h0);
		chk(32'(g2_led), 32'h3);
		step(6);
		reset_n_i = 1'b1;
		step(2);
		u_ctrl_model.send(16'h8001, 0);
		step(3);
		chk(32'(drive), 32'h8001);
		chk(ch_led, 32'h4000_0001);
		chk(32'(mod_led), 32'h1);
		// Surge, then overtemperature, on point 1: trip, latch, recover
		for (int k = 0; k < 2; k++)
		begin
			if (k == 0)
				surge = 16'h0001;
			else
				hot = 16'h0001;
			step(6);
			chk(32'(drive), 32'h8000);
			chk(32'(fault), 32'h0001);
			chk(ch_led, 32'h4000_0002);
			chk(32'(g_fault), 32'h1);
			surge = 16'h0;
			hot = 16'h0;
			step(6);
			chk(32'(fault), 32'h0001);
			u_ctrl_model.send(16'h8000, k);
			step(3);
			chk(32'(fault), 32'h0);
			u_ctrl_model.send(16'h8001, 0);
			step(3);
			chk(32'(drive), 32'h8001);
		end
		// Sustained overcurrent on point 9: short burst passes, long one trips
		u_ctrl_model.send(16'h0100, 0);
		over = 16'h0100;
		step(12);
		over = 16'h0;
		step(6);
		chk(32'(fault), 32'h0);
		over = 16'h0100;
		step(30);
		chk(32'(fault), 32'h0100);
		chk(32'(g_fault), 32'h2);
		chk(32'(drive), 32'h0);
		over = 16'h0;
		u_ctrl_model.send(16'h0000, 0);
		step(3);
		chk(32'(fault), 32'h0);
		// No-load flagged only where enabled
		nl_en = 16'h0004;
		lowc = 16'h000c;
		u_ctrl_model.send(16'h000c, 0);
		step(6);
		chk(32'(noload), 32'h0004);
		lowc = 16'h0;
		// Lost link: low byte holds, high byte takes the default
		hold = 16'h00ff;
		fb_val = 16'hff00;
		lost = 1'b1;
		step(4);
		chk(32'(drive), 32'hff0c);
		lost = 1'b0;
		field(1'b0, 2'h2, 2'h1, 2'h1, 2'h0, 2'h3, 2'h1);
		field(1'b1, 2'h3, 2'h1, 2'h2, 2'h0, 2'h1, 2'h3);
		field(1'b0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1);
		field(1'b0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1);
		blk = 1'b0;
		watch(10);
		chk(32'(pulses), 32'h1);
		chk(32'(blk_on), 32'h0);
		chk(32'(g1_led), 32'h3);
		blk = 1'b1;
		watch(10);
		chk(32'(pulses), 32'h10);
		chk(32'(blk_on), 32'h1);
		cfgd = 1'b0;
		watch(20);
		chk(32'(seen), 32'h3);
		wdog = 1'b1;
		watch(20);
		chk(32'(seen), 32'h4);
		wdog = 1'b0;
		ierr = 1'b1;
		// One full wrap of the burst counter: error code 2 gives three bursts
		watch(128);
		chk(32'(seen), 32'h5);
		chk(32'(bursts), 32'h3);
		ierr = 1'b0;
		cfgd = 1'b1;
		st_fail = 1'b1;
		watch(20);
		chk(32'(seen), 32'h1);
		st_fail = 1'b0;
		upd = 1'b1;
		watch(20);
		chk(32'(seen), 32'h3);
		chk(32'(skew), 32'h0);
		upd = 1'b0;
		watch(10);
		chk(32'(seen), 32'h2);
		final_report();
	end
endmodule : smart_output_fault_supervisor_tb
